//--- shared/rrm_pkg.sv
/*
 Package for the radio register bank: register addresses, reset values,
 control field positions, serial command layout, the control struct and the state enum.
 Assumes one 40 MHz system clock and a four-wire serial port from a master.
*/
package rrm_pkg;
	// Register addresses (six-bit space)
	localparam logic [5:0] A_REV       = 6'h00;
	localparam logic [5:0] A_CTRL      = 6'h03;
	localparam logic [5:0] A_RATE      = 6'h04;
	localparam logic [5:0] A_CFG       = 6'h05;
	localparam logic [5:0] A_SER       = 6'h06;
	localparam logic [5:0] A_RXIE      = 6'h07;
	localparam logic [5:0] A_RXIS      = 6'h08;
	localparam logic [5:0] A_RXDA      = 6'h09;
	localparam logic [5:0] A_RXVA      = 6'h0a;
	localparam logic [5:0] A_RXDB      = 6'h0b;
	localparam logic [5:0] A_RXVB      = 6'h0c;
	localparam logic [5:0] A_TXIE      = 6'h0d;
	localparam logic [5:0] A_TXIS      = 6'h0e;
	localparam logic [5:0] A_TXD       = 6'h0f;
	localparam logic [5:0] A_TXV       = 6'h10;
	localparam logic [5:0] A_CODE_LO   = 6'h11;
	localparam logic [5:0] A_CODE_HI   = 6'h18;
	localparam logic [5:0] A_THL       = 6'h19;
	localparam logic [5:0] A_THH       = 6'h1a;
	localparam logic [5:0] A_WAKE_EN   = 6'h1c;
	localparam logic [5:0] A_WAKE_ST   = 6'h1d;
	localparam logic [5:0] A_ANA       = 6'h20;
	localparam logic [5:0] A_CHAN      = 6'h21;
	localparam logic [5:0] A_RSSI      = 6'h22;
	localparam logic [5:0] A_PA        = 6'h23;
	localparam logic [5:0] A_XTAL      = 6'h24;
	localparam logic [5:0] A_VCO       = 6'h26;
	localparam logic [5:0] A_PWR       = 6'h2e;
	localparam logic [5:0] A_CD        = 6'h2f;
	localparam logic [5:0] A_CLKM      = 6'h32;
	localparam logic [5:0] A_CLKE      = 6'h33;
	localparam logic [5:0] A_SYN       = 6'h38;
	localparam logic [5:0] A_FID_LO    = 6'h3c;
	localparam logic [5:0] A_FID_HI    = 6'h3f;
	// Reset values
	localparam logic [7:0]  R_ZERO     = 8'h00;
	localparam logic [7:0]  R_CFG      = 8'h01;
	localparam logic [7:0]  R_SER      = 8'h03;
	localparam logic [7:0]  R_THL      = 8'h08;
	localparam logic [7:0]  R_THH      = 8'h38;
	localparam logic [7:0]  R_WAKE_ST  = 8'h01;
	localparam logic [7:0]  R_ANA      = 8'h04;
	localparam logic [7:0]  R_SYN      = 8'h64;
	localparam logic [63:0] R_CODE     = 64'h1e8b6a3de0e9b222;
	// Control register field positions
	localparam int C_RX   = 7;
	localparam int C_TX   = 6;
	localparam int C_HALF = 5;
	localparam int C_BYP  = 4;
	localparam int C_MAN  = 3;
	localparam int C_AMP  = 2;
	localparam logic [7:0] CTRL_MASK = 8'hfc;
	// Command byte fields
	localparam int K_WRITE = 7;
	localparam int K_INC   = 6;
	// Wake status pending bit
	localparam int W_PEND = 0;

	// Control outputs carried together
	typedef struct packed {
		logic rx_on;
		logic tx_on;
		logic code_half_select;
		logic lock_bypass;
		logic amp_manual_mode;
		logic amp_on;
	} rrm_ctrl_t;

	// Serial engine states, Gray along the usual path
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_CMD  = 2'b01,
		S_DATA = 2'b11
	} rrm_state_t;
endpackage

//--- design/rrm_bank.sv
/*
 Register bank reached through a four-wire serial slave port (mode 0:
 sample on rising clock, shift on falling). Holds the full map, the
 control register decode and the wake pending flag.
 Assumes the serial clock is well below CLK/4 so edges are seen after
 a two-flop synchroniser; the radio datapath drives the status inputs.
*/
module rrm_bank #(
	parameter bit         HAS_RX   = 1'b1,  // Zero for the transmit-only build
	parameter logic [3:0] DIE_REV  = 4'h0,  // Silicon revision count
	parameter logic [3:0] PART     = 4'h5,  // Arbitrary part code value
	parameter logic [31:0] FACT_ID = 32'h0000_0000 // Arbitrary identity value
) (
	input  wire logic                CLK,         // System clock, 40 MHz
	input  wire logic                RESET_N,     // Async reset, active low
	input  wire logic                SCK,         // Serial clock pin
	input  wire logic                SS_N,        // Slave select pin, active low
	input  wire logic                MOSI,        // Serial data in
	output logic                     MISO,        // Serial data out
	output logic                     MISO_OE,     // High while driving MISO
	input  wire logic [7:0]          RX_IRQ_ST,   // Receive event status
	input  wire logic [7:0]          RX_DATA_A,   // Receive byte A
	input  wire logic [7:0]          RX_VALID_A,  // Receive valid A
	input  wire logic [7:0]          RX_DATA_B,   // Receive byte B
	input  wire logic [7:0]          RX_VALID_B,  // Receive valid B
	input  wire logic [7:0]          TX_IRQ_ST,   // Transmit event status
	input  wire logic [7:0]          STRENGTH,    // Signal strength value
	input  wire logic                WAKE_EVENT,  // Oscillator-ready pulse
	output rrm_pkg::rrm_ctrl_t       CTRL,        // Decoded control bits
	output logic [63:0]              CODE         // Spreading code
);
	import rrm_pkg::*;

	logic [7:0] regs [0:63];
	logic [2:0] sck_s;
	logic [1:0] ss_s;
	logic [1:0] mosi_s;
	rrm_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] shift_in, shift_out;
	logic [5:0] addr;
	logic       wr_mode, inc_mode;
	logic       wake_pend;
	logic       byte_done, rd_strobe;
	logic [7:0] next_byte;
	logic [5:0] ld_addr;

	// True for addresses that hold storage software may write
	function automatic logic writable(input logic [5:0] a);
		logic rx_only;
		rx_only = (a == A_RXIE) || (a == A_THL) || (a == A_THH);
		if (rx_only)
			return HAS_RX;
		case (a)
			A_CTRL, A_RATE, A_CFG, A_SER, A_TXIE, A_TXD, A_TXV,
			A_WAKE_EN, A_ANA, A_CHAN, A_PA, A_XTAL, A_VCO, A_PWR,
			A_CD, A_CLKM, A_CLKE, A_SYN: return 1'b1;
			default: return (a >= A_CODE_LO) && (a <= A_CODE_HI);
		endcase
	endfunction

	// Read data for an address; unmapped reads as zero
	function automatic logic [7:0] rd_data(input logic [5:0] a);
		logic [7:0] v;
		v = R_ZERO;
		if (writable(a))
			v = regs[a];
		case (a)
			A_REV:     v = {DIE_REV, PART};
			A_RXIS:    v = HAS_RX ? RX_IRQ_ST : R_ZERO;
			A_RXDA:    v = HAS_RX ? RX_DATA_A : R_ZERO;
			A_RXVA:    v = HAS_RX ? RX_VALID_A : R_ZERO;
			A_RXDB:    v = HAS_RX ? RX_DATA_B : R_ZERO;
			A_RXVB:    v = HAS_RX ? RX_VALID_B : R_ZERO;
			A_TXIS:    v = TX_IRQ_ST;
			A_RSSI:    v = HAS_RX ? STRENGTH : R_ZERO;
			A_WAKE_ST: v = {7'h00, wake_pend};
			default: begin
				if (a >= A_FID_LO)
					v = FACT_ID[8*(a - A_FID_LO) +: 8];
			end
		endcase
		return v;
	endfunction

	// Two-flop synchronisers plus a third stage for edge finding
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sck_s  <= 3'h0;
			ss_s   <= 2'h3;
			mosi_s <= 2'h0;
		end else begin
			sck_s  <= {sck_s[1:0], SCK};
			ss_s   <= {ss_s[0], SS_N};
			mosi_s <= {mosi_s[0], MOSI};
		end
	end

	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];
	wire sel      = ~ss_s[1];

	assign next_byte = {shift_in[6:0], mosi_s[1]};
	assign byte_done = sel && sck_rise && (bit_cnt == 3'h7);

	// Serial engine: command byte then data bytes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state    <= S_IDLE;
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
			addr     <= 6'h00;
			wr_mode  <= 1'b0;
			inc_mode <= 1'b0;
		end else if (!sel) begin
			state   <= S_IDLE;
			bit_cnt <= 3'h0;
		end else begin
			if (state == S_IDLE)
				state <= S_CMD;
			if (sck_rise) begin
				shift_in <= next_byte;
				bit_cnt  <= bit_cnt + 3'h1;
			end
			if (byte_done) begin
				unique case (state)
					S_IDLE, S_CMD: begin
						wr_mode  <= next_byte[K_WRITE];
						inc_mode <= next_byte[K_INC];
						addr     <= next_byte[5:0];
						state    <= S_DATA;
					end
					S_DATA: begin
						if (inc_mode)
							addr <= addr + 6'h01;
					end
				endcase
			end
		end
	end

	// A read of a data byte completes when its last bit is sampled
	assign rd_strobe = byte_done && (state == S_DATA) && !wr_mode;

	// Address loaded next: burst step, repeat, or the command's own address
	assign ld_addr = (state == S_DATA) ? (inc_mode ? addr + 6'h01 : addr) : next_byte[5:0];

	// Storage writes; read-only and unmapped addresses ignore them
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < 64; i++)
				regs[i] <= R_ZERO;
			regs[A_CFG] <= R_CFG;
			regs[A_SER] <= R_SER;
			regs[A_THL] <= R_THL;
			regs[A_THH] <= R_THH;
			regs[A_ANA] <= R_ANA;
			regs[A_SYN] <= R_SYN;
			for (int i = 0; i < 8; i++)
				regs[A_CODE_LO + i] <= R_CODE[8*i +: 8];
		end else if (byte_done && state == S_DATA && wr_mode && writable(addr)) begin
			if (addr == A_CTRL)
				regs[addr] <= next_byte & CTRL_MASK;
			else
				regs[addr] <= next_byte;
		end
	end

	// Wake pending: set wins over the read clear
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			wake_pend <= 1'b1;
		else if (WAKE_EVENT)
			wake_pend <= 1'b1;
		else if (rd_strobe && addr == A_WAKE_ST)
			wake_pend <= 1'b0;
	end

	// Output shifter: load at a byte boundary, shift on falling edges
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			shift_out <= 8'h00;
			MISO      <= 1'b0;
			MISO_OE   <= 1'b0;
		end else begin
			MISO_OE <= sel;
			if (!sel) begin
				MISO <= 1'b0;
			end else if (byte_done) begin
				// Loaded half a serial clock early so the MSB is ready at the next fall
				shift_out <= rd_data(ld_addr);
			end else if (sck_fall && bit_cnt == 3'h0) begin
				MISO      <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b0};
			end else if (sck_fall) begin
				MISO      <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end

	// Control and code outputs come from registered storage
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CTRL <= '0;
			CODE <= R_CODE;
		end else begin
			CTRL.rx_on            <= HAS_RX & regs[A_CTRL][C_RX];
			CTRL.tx_on            <= regs[A_CTRL][C_TX];
			CTRL.code_half_select <= regs[A_CTRL][C_HALF];
			CTRL.lock_bypass      <= regs[A_CTRL][C_BYP];
			CTRL.amp_manual_mode  <= regs[A_CTRL][C_MAN];
			CTRL.amp_on           <= regs[A_CTRL][C_AMP];
			for (int i = 0; i < 8; i++)
				CODE[8*i +: 8] <= regs[A_CODE_LO + i];
		end
	end

	// Checks
	property p_wake_clear;
		@(posedge CLK) disable iff (!RESET_N)
		(rd_strobe && addr == A_WAKE_ST && !WAKE_EVENT) |=> !wake_pend;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");

	property p_wake_set;
		@(posedge CLK) disable iff (!RESET_N) WAKE_EVENT |=> wake_pend;
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake event lost");

	property p_rx_mode;
		@(posedge CLK) disable iff (!RESET_N)
		(regs[A_CTRL][C_RX] && HAS_RX) |=> CTRL.rx_on;
	endproperty
	a_rx_mode: assert property (p_rx_mode) else $error("rx mode not entered");

	property p_tx_mode;
		@(posedge CLK) disable iff (!RESET_N)
		$fell(regs[A_CTRL][C_TX]) |=> !CTRL.tx_on;
	endproperty
	a_tx_mode: assert property (p_tx_mode) else $error("tx mode not left");

	property p_ctrl_rsvd;
		@(posedge CLK) disable iff (!RESET_N) regs[A_CTRL][1:0] == 2'h0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");

	property p_rev_ro;
		@(posedge CLK) disable iff (!RESET_N)
		(byte_done && ld_addr == A_REV) |=> shift_out == {DIE_REV, PART};
	endproperty
	a_rev_ro: assert property (p_rev_ro) else $error("revision changed");

	property p_unmapped;
		@(posedge CLK) disable iff (!RESET_N)
		(byte_done && ld_addr == 6'h01) |=> shift_out == R_ZERO;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

	property p_code_order;
		@(posedge CLK) disable iff (!RESET_N)
		##1 CODE[7:0] == $past(regs[A_CODE_LO]);
	endproperty
	a_code_order: assert property (p_code_order) else $error("code byte order");

	// Identity bytes leave low byte first
	property p_fid_low;
		@(posedge CLK) disable iff (!RESET_N)
		(byte_done && ld_addr == A_FID_LO) |=> shift_out == FACT_ID[7:0];
	endproperty
	a_fid_low: assert property (p_fid_low) else $error("identity low byte");

	// Output enable follows the synchronised select
	property p_oe_sel;
		@(posedge CLK) disable iff (!RESET_N)
		sel |=> MISO_OE;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("output not enabled");

	property p_idle_quiet;
		@(posedge CLK) disable iff (!RESET_N)
		!sel |=> (!MISO_OE && !MISO);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("output not idle");

	// A cut frame drops its partial byte
	property p_bit_clear;
		@(posedge CLK) disable iff (!RESET_N)
		!sel |=> bit_cnt == 3'h0;
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("partial byte kept");

	// Command byte decode into direction, increment and address
	property p_cmd_latch;
		@(posedge CLK) disable iff (!RESET_N)
		(byte_done && state != S_DATA) |=> {wr_mode, inc_mode, addr} == $past(next_byte);
	endproperty
	a_cmd_latch: assert property (p_cmd_latch) else $error("command decode");

	property p_burst_step;
		@(posedge CLK) disable iff (!RESET_N)
		(byte_done && state == S_DATA && inc_mode) |=> addr == $past(addr) + 6'h01;
	endproperty
	a_burst_step: assert property (p_burst_step) else $error("burst step");

	// Writes cannot touch the wake flag; only events and reads do
	property p_wake_hold;
		@(posedge CLK) disable iff (!RESET_N)
		(!WAKE_EVENT && !(rd_strobe && addr == A_WAKE_ST)) |=> $stable(wake_pend);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake flag changed");

	property p_ctrl_write;
		@(posedge CLK) disable iff (!RESET_N)
		(byte_done && state == S_DATA && wr_mode && addr == A_CTRL)
		|=> regs[A_CTRL] == ($past(next_byte) & CTRL_MASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write");

	// Transmit-only build never enters receive mode
	property p_rx_absent;
		@(posedge CLK) disable iff (!RESET_N)
		(HAS_RX == 1'b0) |-> !CTRL.rx_on;
	endproperty
	a_rx_absent: assert property (p_rx_absent) else $error("rx mode in tx build");
endmodule

//--- sim/rrm_spi_master.sv
/*
 Serial master model for the radio register bank: mode 0, MSB first,
 one command byte then a burst of data bytes held in buf_q.
 Assumes the bench's 40 MHz clock; the serial clock runs at 200 ns.
*/
module rrm_spi_master (
	input  wire logic clk,   // System clock, paces the serial clock
	input  wire logic miso,  // Resolved serial data from the slave
	output logic      sck,   // Serial clock, idle low
	output logic      ss_n,  // Slave select, active low
	output logic      mosi   // Serial data to the slave
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] buf_q [64];

	// Idle frame; the clock stands still between frames
	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end

	// One byte each way; four system clocks per half period
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			rx[i] = miso;
			repeat (4) @(negedge clk);
			sck = 1'b0;
		end
	endtask

	// Whole frame; read bytes replace the sent ones in buf_q
	task automatic access(input logic [7:0] cmd, input int n);
		logic [7:0] junk;
		@(negedge clk);
		ss_n = 1'b0;
		shift_byte(cmd, junk);
		for (int b = 0; b < n; b++) begin
			shift_byte(buf_q[b], buf_q[b]);
		end
		repeat (4) @(negedge clk);
		ss_n = 1'b1;
		mosi = ~mosi; // Released line, no pull: do not leave a stale level
		repeat (8) @(negedge clk);
	endtask
endmodule

//--- sim/rrm_bank_bench.sv
/*
 Self-checking bench for the radio register bank: full-map sweeps after
 reset and after a write, control decode, wake flag, transmit-only build.
 Assumes rrm_pkg, rrm_bank and the serial master model compile first.
*/
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("Error at %0t ns: got %h expected %h", $time, g, e); end end

module rrm_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rrm_pkg::*;

	localparam logic [3:0]  REV_B  = 4'h2;          // Arbitrary revision for the run
	localparam logic [3:0]  PART_B = 4'h5;          // Arbitrary part code value
	localparam logic [31:0] FID_B  = 32'h5a3c_9617; // Arbitrary identity value

	logic        CLK, RESET_N, sck, ss_n, mosi, wake, sel_tx;
	logic        miso_a, oe_a, miso_b, oe_b, miso_w;
	rrm_ctrl_t   ctrl, ctrl_b;
	logic [63:0] code;
	logic [7:0]  st [7] = '{8'h41, 8'h52, 8'h63, 8'h74, 8'h85, 8'h96, 8'ha7};
	int          failures = 0;
	int          samples_checked = 0;

	// Full build and transmit-only build share the serial lines
	rrm_bank #(.HAS_RX(1'b1), .DIE_REV(REV_B), .PART(PART_B), .FACT_ID(FID_B)) u_dut (
		.CLK(CLK), .RESET_N(RESET_N), .SCK(sck), .SS_N(ss_n), .MOSI(mosi),
		.MISO(miso_a), .MISO_OE(oe_a), .RX_IRQ_ST(st[0]), .RX_DATA_A(st[1]),
		.RX_VALID_A(st[2]), .RX_DATA_B(st[3]), .RX_VALID_B(st[4]), .TX_IRQ_ST(st[5]),
		.STRENGTH(st[6]), .WAKE_EVENT(wake), .CTRL(ctrl), .CODE(code));
	rrm_bank #(.HAS_RX(1'b0), .DIE_REV(REV_B), .PART(PART_B), .FACT_ID(FID_B)) u_txo (
		.CLK(CLK), .RESET_N(RESET_N), .SCK(sck), .SS_N(ss_n), .MOSI(mosi),
		.MISO(miso_b), .MISO_OE(oe_b), .RX_IRQ_ST(st[0]), .RX_DATA_A(st[1]),
		.RX_VALID_A(st[2]), .RX_DATA_B(st[3]), .RX_VALID_B(st[4]), .TX_IRQ_ST(st[5]),
		.STRENGTH(st[6]), .WAKE_EVENT(wake), .CTRL(ctrl_b), .CODE());
	rrm_spi_master u_mst (.clk(CLK), .miso(miso_w), .sck(sck), .ss_n(ss_n), .mosi(mosi));

	// Only the selected build drives the master's input
	assign miso_w = sel_tx ? (oe_b ? miso_b : 1'bz) : (oe_a ? miso_a : 1'bz);

	// 40 MHz system clock
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	// Expected read value; rx low means the transmit-only build
	function automatic logic [7:0] exp_byte(input logic [5:0] a, input bit rx, input bit wr,
		input bit wk);
		logic [7:0] w;
		w = {2'b00, a} ^ 8'ha5;
		case (a) inside
			6'h00: return {REV_B, PART_B};
			6'h03: return wr ? (w & 8'hfc) : 8'h00;
			6'h04, 6'h0d, 6'h0f, 6'h10, 6'h1c, 6'h21, 6'h23, 6'h24, 6'h26, 6'h2e, 6'h2f,
			6'h32, 6'h33: return wr ? w : 8'h00;
			6'h05: return wr ? w : 8'h01;
			6'h06: return wr ? w : 8'h03;
			6'h07: return (rx && wr) ? w : 8'h00;
			[6'h08:6'h0c]: return rx ? st[a - 6'h08] : 8'h00;
			6'h0e: return st[5];
			[6'h11:6'h18]: return wr ? w : 8'(64'h1e8b6a3de0e9b222 >> (8 * (a - 6'h11)));
			6'h19: return rx ? (wr ? w : 8'h08) : 8'h00;
			6'h1a: return rx ? (wr ? w : 8'h38) : 8'h00;
			6'h1d: return {7'h00, wk};
			6'h20: return wr ? w : 8'h04;
			6'h22: return rx ? st[6] : 8'h00;
			6'h38: return wr ? w : 8'h64;
			[6'h3c:6'h3f]: return 8'(FID_B >> (8 * (a - 6'h3c)));
			default: return 8'h00;
		endcase
	endfunction

	// Incrementing read of the whole map from address zero
	task automatic rd_map(input bit rx, input bit wr, input bit wk);
		sel_tx = !rx;
		u_mst.access(8'h40, 64);
		`CHK({oe_a, oe_b}, 2'b00)
		for (int a = 0; a < 64; a++) begin
			`CHK(u_mst.buf_q[a], exp_byte(6'(a), rx, wr, wk))
		end
	endtask

	// Incrementing write of every address with a distinct pattern
	task automatic wr_map();
		logic [63:0] e;
		for (int a = 0; a < 64; a++) begin
			u_mst.buf_q[a] = 8'(a) ^ 8'ha5;
		end
		u_mst.access(8'hc0, 64);
		for (int a = 0; a < 8; a++) begin
			e[8*a +: 8] = 8'(a + 17) ^ 8'ha5;
		end
		`CHK(code, e)
		`CHK(ctrl, rrm_ctrl_t'(6'b101001))
	endtask

	// Each control bit alone, then reserved bits only, then clear
	task automatic ctrl_modes();
		logic [7:0] v [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h03, 8'h00};
		sel_tx = 1'b0;
		foreach (v[i]) begin
			u_mst.buf_q[0] = v[i];
			u_mst.access(8'h83, 1);
			`CHK(ctrl, rrm_ctrl_t'(v[i][7:2]))
			`CHK(ctrl_b, rrm_ctrl_t'({1'b0, v[i][6:2]}))
		end
	endtask

	// New wake event shows once, then the read clears it
	task automatic wake_flag();
		@(negedge CLK);
		wake = 1'b1;
		@(negedge CLK);
		wake = 1'b0;
		u_mst.access(8'h1d, 1);
		`CHK(u_mst.buf_q[0], 8'h01)
		u_mst.access(8'h1d, 1);
		`CHK(u_mst.buf_q[0], 8'h00)
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence; reset sweeps first so the first one still sees the wake flag pending
	initial begin
		RESET_N = 1'b0;
		wake = 1'b0;
		sel_tx = 1'b0;
		repeat (5) @(negedge CLK);
		RESET_N = 1'b1;
		repeat (3) @(negedge CLK);
		rd_map(1'b1, 1'b0, 1'b1);
		rd_map(1'b0, 1'b0, 1'b0);
		wr_map();
		rd_map(1'b1, 1'b1, 1'b0);
		rd_map(1'b0, 1'b1, 1'b0);
		ctrl_modes();
		wake_flag();
		wrap_up();
	end

	// Watchdog: the run needs about 0.56 ms, so 1 ms leaves margin
	initial begin
		#1000000;
		failures++;
		wrap_up();
	end
endmodule
